// file: design/tsodr_regs.sv
// register bank: security word, oscillator counters, ram size and
// debug snapshots; assumes one core clock, oscillators arrive as pins.
`timescale 1ns/1ps
`default_nettype none
module tsodr_regs #(
	parameter logic [31:0] RAM_BYTES = 32'h00080000
) (
	// clock and resets
	input  wire logic                    CLK,
	input  wire logic                    RST,
	input  wire logic                    POR_RST,
	// processor-status access
	input  wire tsodr_pkg::tsodr_req_t   PS_REQ,
	output var  logic [31:0]             PS_RDATA,
	output var  logic                    PS_RVALID,
	// fuse copy of the security word
	input  wire logic [31:0]             OTP_SEC_WORD,
	input  wire logic                    OTP_SEC_VALID,
	output var  logic                    SEC_LOADED,
	output var  tsodr_pkg::tsodr_locks_t SEC_LOCKS,
	// ring oscillators
	input  wire logic [3:0]              OSC_IN,
	output var  logic [3:0]              OSC_RUN,
	// debug
	input  wire logic                    DEBUG_MODE,
	input  wire logic                    DBG_ENTRY,
	input  wire tsodr_pkg::tsodr_thread_t THREAD_STATE,
	output var  logic [7:0]              TARGET_THREAD_ID
);
	import tsodr_pkg::*;

	logic [31:0]              sec;
	logic                     loaded;
	logic [1:0]               osc_ctrl;
	logic [OSC_CNT_WIDTH-1:0] cnt [4];
	logic [3:0]               s1;
	logic [3:0]               s2;
	logic [3:0]               s3;
	logic [10:0]              saved_status_word;
	logic [31:0]              saved_program_counter;
	logic [31:0]              saved_stack_pointer;
	logic [TSEL_WIDTH-1:0]    tsel;
	logic [31:0]              next_rdata;
	logic                     wr_dbg;

	// debug-writable fields only take writes in debug mode
	assign wr_dbg = PS_REQ.wr && DEBUG_MODE; // [R24]

	// fuse copy wins; writes before the copy arrives are dropped
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			sec <= SEC_RESET;
			loaded <= 1'b0;
		end else if (OTP_SEC_VALID && !loaded) begin
			sec <= OTP_SEC_WORD & SEC_MASK; // [R1]
			loaded <= 1'b1;
		end else if (PS_REQ.wr && loaded && PS_REQ.addr == OFS_SECURITY
				&& !sec[SEC_WRITE_LOCK_BIT]) begin // [R2]
			sec <= PS_REQ.wdata & SEC_MASK;
		end
	end

	assign SEC_LOADED = loaded;
	always_comb begin
		SEC_LOCKS.global_debug_off   = sec[SEC_GLOBAL_DBG_BIT]; // [R3]
		SEC_LOCKS.otp_read_lock      = sec[SEC_OTP_RD_BIT]; // [R4]
		SEC_LOCKS.fuse_prog_lock     = sec[SEC_FUSE_PROG_BIT]; // [R5]
		SEC_LOCKS.otp_combined       = sec[SEC_COMBINED_BIT]; // [R6]
		SEC_LOCKS.fuse_boot_override = sec[SEC_BOOT_OVR_BIT]; // [R7]
		SEC_LOCKS.jtag_cfg_lock      = sec[SEC_JTAG_CFG_BIT]; // [R8]
		SEC_LOCKS.jtag_tap_off       = sec[SEC_JTAG_TAP_BIT]; // [R9]
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			osc_ctrl <= OSC_CTRL_RESET; // [R11]
		end else if (PS_REQ.wr && PS_REQ.addr == OFS_OSC_CTRL) begin
			osc_ctrl <= PS_REQ.wdata[1:0];
		end
	end

	// run enables: 0,1 core pair, 2,3 peripheral pair
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			OSC_RUN <= 4'h0;
		end else begin
			OSC_RUN[0] <= osc_ctrl[OSC_CORE_RUN_BIT]; // [R11] [R10]
			OSC_RUN[1] <= osc_ctrl[OSC_CORE_RUN_BIT];
			OSC_RUN[2] <= osc_ctrl[OSC_PERIPH_RUN_BIT];
			OSC_RUN[3] <= osc_ctrl[OSC_PERIPH_RUN_BIT];
		end
	end

	// oscillator edges are asynchronous; counters only see the
	// synchronised edge, so the last few edges land after a stop
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_osc
			always_ff @(posedge CLK or posedge POR_RST) begin
				if (POR_RST) begin
					s1[g] <= 1'b0;
					s2[g] <= 1'b0;
					s3[g] <= 1'b0;
				end else begin
					s1[g] <= OSC_IN[g]; // [R13]
					s2[g] <= s1[g];
					s3[g] <= s2[g];
				end
			end
			// system reset leaves the count alone
			always_ff @(posedge CLK or posedge POR_RST) begin
				if (POR_RST) begin
					cnt[g] <= '0;
				end else if (s2[g] && !s3[g]) begin
					cnt[g] <= cnt[g] + 1'b1; // [R10] [R16]
				end
			end
		end
	endgenerate

	// entry capture wins over a same-cycle software write
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			saved_status_word <= '0;
			saved_program_counter <= '0;
			saved_stack_pointer <= '0;
		end else if (DBG_ENTRY) begin
			saved_status_word <= THREAD_STATE.status & SSR_MASK; // [R18] [R19] [R20]
			saved_program_counter <= THREAD_STATE.pc; // [R21]
			saved_stack_pointer <= THREAD_STATE.sp; // [R22]
		end else if (wr_dbg) begin
			if (PS_REQ.addr == OFS_DEBUG_STATUS_SNAPSHOT) begin
				saved_status_word <= (saved_status_word & ~SSR_WMASK)
					| (PS_REQ.wdata[10:0] & SSR_WMASK); // [R19] [R24]
			end
			if (PS_REQ.addr == OFS_DEBUG_PC_SNAPSHOT) begin
				saved_program_counter <= PS_REQ.wdata; // [R24]
			end
			if (PS_REQ.addr == OFS_DEBUG_STACK_SNAPSHOT) begin
				saved_stack_pointer <= PS_REQ.wdata;
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			tsel <= '0;
		end else if (wr_dbg && PS_REQ.addr == OFS_DBG_TSEL) begin
			tsel <= PS_REQ.wdata[TSEL_WIDTH-1:0]; // [R23]
		end
	end
	assign TARGET_THREAD_ID = tsel;

	always_comb begin
		next_rdata = 32'h00000000;
		if (PS_REQ.addr == OFS_SECURITY) begin
			next_rdata = sec;
		end else if (PS_REQ.addr == OFS_OSC_CTRL) begin
			next_rdata = {30'h00000000, osc_ctrl};
		end else if (PS_REQ.addr == OFS_OSC_CNT0) begin
			next_rdata = {16'h0000, cnt[0]}; // [R14] [R15]
		end else if (PS_REQ.addr == OFS_OSC_CNT1) begin
			next_rdata = {16'h0000, cnt[1]};
		end else if (PS_REQ.addr == OFS_OSC_CNT2) begin
			next_rdata = {16'h0000, cnt[2]};
		end else if (PS_REQ.addr == OFS_OSC_CNT3) begin
			next_rdata = {16'h0000, cnt[3]};
		end else if (PS_REQ.addr == OFS_RAM_SIZE) begin
			next_rdata = RAM_BYTES & RAM_ADDR_MASK; // [R17]
		end else if (PS_REQ.addr == OFS_DEBUG_STATUS_SNAPSHOT) begin
			next_rdata = {21'h000000, saved_status_word};
		end else if (PS_REQ.addr == OFS_DEBUG_PC_SNAPSHOT) begin
			next_rdata = saved_program_counter;
		end else if (PS_REQ.addr == OFS_DEBUG_STACK_SNAPSHOT) begin
			next_rdata = saved_stack_pointer;
		end else if (PS_REQ.addr == OFS_DBG_TSEL) begin
			next_rdata = {24'h000000, tsel};
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			PS_RDATA <= 32'h00000000;
			PS_RVALID <= 1'b0;
		end else begin
			PS_RVALID <= PS_REQ.rd;
			if (PS_REQ.rd) begin
				PS_RDATA <= next_rdata;
			end
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST || POR_RST);

	sequence s_read(logic [7:0] a);
		PS_REQ.rd && PS_REQ.addr == a;
	endsequence

	sequence s_write(logic [7:0] a);
		PS_REQ.wr && PS_REQ.addr == a;
	endsequence

	// debug-writable access: strobe, address and debug mode together
	sequence s_dbg_write(logic [7:0] a);
		PS_REQ.wr && DEBUG_MODE && PS_REQ.addr == a;
	endsequence

	sequence s_sync_rise(int i);
		s2[i] && !s3[i];
	endsequence

	a_fuse_copy_load: assert property ( // [R1]
		OTP_SEC_VALID && !loaded |=> sec == ($past(OTP_SEC_WORD) & SEC_MASK)
			&& loaded)
		else $error("security word not loaded from fuse copy");

	a_sec_write_lock: assert property ( // [R2]
		loaded && sec[SEC_WRITE_LOCK_BIT] |=> $stable(sec))
		else $error("locked security word changed");

	a_lock_outputs_follow: assert property ( // [R9]
		SEC_LOCKS.jtag_tap_off == sec[0] && SEC_LOCKS.otp_read_lock == sec[9]
			&& SEC_LOCKS.global_debug_off == sec[14])
		else $error("lock output disagrees with security word");

	a_osc_run_map: assert property ( // [R11]
		1'b1 |=> OSC_RUN[3:2] == {2{$past(osc_ctrl[0])}}
			&& OSC_RUN[1:0] == {2{$past(osc_ctrl[1])}})
		else $error("oscillator run map wrong");

	a_osc_edge_count: assert property ( // [R13]
		s_sync_rise(2) |=> cnt[2] == $past(cnt[2]) + 16'h0001)
		else $error("oscillator edge not counted after sync");

	a_snap_capture: assert property ( // [R21]
		DBG_ENTRY |=> saved_program_counter == $past(THREAD_STATE.pc)
			&& saved_stack_pointer == $past(THREAD_STATE.sp)
			&& saved_status_word == ($past(THREAD_STATE.status) & SSR_MASK))
		else $error("debug snapshot not captured");

	a_dbg_write_gate: assert property ( // [R24]
		!DEBUG_MODE && !DBG_ENTRY |=> $stable(saved_program_counter) && $stable(saved_stack_pointer)
			&& $stable(tsel))
		else $error("debug field written outside debug mode");

	a_ssr_dual_ro: assert property ( // [R19]
		!DBG_ENTRY |=> saved_status_word[SSR_DUAL_BIT] == $past(saved_status_word[SSR_DUAL_BIT]))
		else $error("dual issue bit changed by software");

	a_ram_size_read: assert property ( // [R17]
		s_read(OFS_RAM_SIZE) |=> PS_RVALID
			&& PS_RDATA == (RAM_BYTES & RAM_ADDR_MASK))
		else $error("ram size read wrong");

	a_count_upper_zero: assert property ( // [R14]
		s_read(OFS_OSC_CNT0) |=> PS_RDATA[31:16] == 16'h0000
			&& PS_RDATA[15:0] == $past(cnt[0]))
		else $error("count read wrong");

	a_read_valid_pulse: assert property ( // [R14]
		1'b1 |=> PS_RVALID == $past(PS_REQ.rd))
		else $error("read valid not a one-cycle answer");

	a_rdata_hold: assert property ( // [R14]
		!PS_REQ.rd |=> $stable(PS_RDATA))
		else $error("read data changed without a read");

	a_sec_unlocked_write: assert property ( // [R2]
		s_write(OFS_SECURITY) ##0 (loaded && !sec[SEC_WRITE_LOCK_BIT])
			|=> sec == ($past(PS_REQ.wdata) & SEC_MASK))
		else $error("open security word not written");

	a_sec_before_load: assert property ( // [R1]
		!loaded && !OTP_SEC_VALID |=> $stable(sec) && !loaded)
		else $error("security word changed before fuse copy");

	a_fuse_later_ignored: assert property ( // [R1]
		loaded && !(PS_REQ.wr && PS_REQ.addr == OFS_SECURITY)
			|=> $stable(sec) && loaded)
		else $error("later fuse copy changed security word");

	a_sec_reserved_zero: assert property ( // [R1]
		(sec & ~SEC_MASK) == 32'h00000000)
		else $error("reserved security bit set");

	a_lock_slices_rest: assert property ( // [R5] [R6] [R7] [R8]
		SEC_LOCKS.fuse_prog_lock == sec[8] && SEC_LOCKS.otp_combined == sec[7]
			&& SEC_LOCKS.fuse_boot_override == sec[5]
			&& SEC_LOCKS.jtag_cfg_lock == sec[4])
		else $error("lock output disagrees with security word");

	a_osc_ctrl_write: assert property ( // [R11]
		s_write(OFS_OSC_CTRL) |=> osc_ctrl == $past(PS_REQ.wdata[1:0]))
		else $error("oscillator control not written");

	a_osc_ctrl_hold: assert property ( // [R11]
		!(PS_REQ.wr && PS_REQ.addr == OFS_OSC_CTRL) |=> $stable(osc_ctrl))
		else $error("oscillator control changed without write");

	a_sync_chain: assert property ( // [R13]
		1'b1 |=> s2 == $past(s1) && s3 == $past(s2))
		else $error("oscillator synchroniser chain broken");

	a_count_step: assert property ( // [R10]
		s_sync_rise(0) |=> cnt[0] == $past(cnt[0]) + 16'h0001)
		else $error("tile cell edge not counted");

	a_count_idle_hold: assert property ( // [R10]
		!(s2[0] && !s3[0]) |=> $stable(cnt[0]))
		else $error("tile cell count moved without an edge");

	a_tsel_dbg_write: assert property ( // [R23]
		s_dbg_write(OFS_DBG_TSEL) |=> tsel == $past(PS_REQ.wdata[7:0]))
		else $error("thread select not written in debug mode");

	a_spc_dbg_write: assert property ( // [R24]
		s_dbg_write(OFS_DEBUG_PC_SNAPSHOT) ##0 !DBG_ENTRY |=> saved_program_counter == $past(PS_REQ.wdata))
		else $error("program counter snapshot not written");

	a_ssp_dbg_write: assert property ( // [R24]
		s_dbg_write(OFS_DEBUG_STACK_SNAPSHOT) ##0 !DBG_ENTRY |=> saved_stack_pointer == $past(PS_REQ.wdata))
		else $error("stack snapshot not written");

	a_ssr_dbg_write: assert property ( // [R24]
		s_dbg_write(OFS_DEBUG_STATUS_SNAPSHOT) ##0 !DBG_ENTRY |=> (saved_status_word & SSR_WMASK)
			== ($past(PS_REQ.wdata[10:0]) & SSR_WMASK))
		else $error("status snapshot not written");

	a_ssr_reserved_zero: assert property ( // [R19]
		(saved_status_word & ~SSR_MASK) == 11'h000)
		else $error("reserved status snapshot bit set");

	a_count3_read: assert property ( // [R15]
		s_read(OFS_OSC_CNT3) |=> PS_RDATA == {16'h0000, $past(cnt[3])})
		else $error("peripheral wire count read wrong");

	a_unmapped_read_zero: assert property ( // [R15]
		s_read(8'h0B) |=> PS_RDATA == 32'h00000000)
		else $error("unmapped read not zero");

	a_tsel_read: assert property ( // [R23]
		s_read(OFS_DBG_TSEL) |=> PS_RDATA == {24'h000000, $past(tsel)})
		else $error("thread select read wrong");

endmodule // tsodr_regs
`default_nettype wire

// file: design/tsodr_pkg.sv
// constants and carrier types of the tile security, oscillator and debug
// register bank; assumes one core clock and processor-status accesses.
// Notes on behaviour
// [R1] security word loaded from fuse copy at start
// [R2] top security bit blocks later writes
// [R3] bit 14 refuses global debug access
// [R4] bit 9 denies fuse memory reads
// [R5] bit 8 blocks the fuse programming port
// [R6] bit 7 combines fuse memory address space
// [R7] bit 5 forces boot from fuse memory
// [R8] bit 4 rejects jtag clock/boot config access
// [R9] bit 0 disables the jtag debug port
// [R10] four oscillator counters, started and stopped
// [R11] control bit 1 core, bit 0 peripheral
// [R12] software reads counts ten cycles after stop
// [R13] oscillators run asynchronous to tile clock
// [R14] counts in low half, upper bits zero
// [R15] counts map tile cell, wire, periph cell, wire
// [R16] counts survive system reset
// [R17] ram size in bits 31:2, low bits zero
// [R18] debug entry captures thread status word
// [R19] status bits 10,9,8 read-only,7,6
// [R20] status bits 4,3,2,1,0
// [R21] debug entry captures saved program counter
// [R22] debug entry captures saved stack pointer
// [R23] thread select holds core id in 7:0
// [R24] debug-writable fields writable only in debug
package tsodr_pkg;
	localparam logic [7:0] OFS_SECURITY = 8'h05;
	localparam logic [7:0] OFS_OSC_CTRL = 8'h06;
	localparam logic [7:0] OFS_OSC_CNT0 = 8'h07;
	localparam logic [7:0] OFS_OSC_CNT1 = 8'h08;
	localparam logic [7:0] OFS_OSC_CNT2 = 8'h09;
	localparam logic [7:0] OFS_OSC_CNT3 = 8'h0A;
	localparam logic [7:0] OFS_RAM_SIZE = 8'h0C;
	localparam logic [7:0] OFS_DEBUG_STATUS_SNAPSHOT  = 8'h10;
	localparam logic [7:0] OFS_DEBUG_PC_SNAPSHOT  = 8'h11;
	localparam logic [7:0] OFS_DEBUG_STACK_SNAPSHOT  = 8'h12;
	localparam logic [7:0] OFS_DBG_TSEL = 8'h13;

	localparam int SEC_WRITE_LOCK_BIT = 31;
	localparam int SEC_GLOBAL_DBG_BIT = 14;
	localparam int SEC_OTP_RD_BIT     = 9;
	localparam int SEC_FUSE_PROG_BIT  = 8;
	localparam int SEC_COMBINED_BIT   = 7;
	localparam int SEC_BOOT_OVR_BIT   = 5;
	localparam int SEC_JTAG_CFG_BIT   = 4;
	localparam int SEC_JTAG_TAP_BIT   = 0;
	localparam logic [31:0] SEC_MASK  = 32'h800043B1;
	localparam logic [31:0] SEC_RESET = 32'h00000000;

	localparam int OSC_CORE_RUN_BIT   = 1;
	localparam int OSC_PERIPH_RUN_BIT = 0;
	localparam logic [1:0] OSC_CTRL_RESET = 2'h0;
	localparam int OSC_CNT_WIDTH = 16;
	// software waits this long after a stop before reading counts
	localparam int OSC_SETTLE_CYCLES = 10;

	localparam logic [10:0] SSR_MASK  = 11'h7DF;
	localparam logic [10:0] SSR_WMASK = 11'h6DF;
	localparam int SSR_DUAL_BIT = 8;
	localparam int TSEL_WIDTH = 8;
	localparam logic [31:0] RAM_ADDR_MASK = 32'hFFFFFFFC;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} tsodr_req_t;

	typedef struct packed {
		logic [10:0] status;
		logic [31:0] pc;
		logic [31:0] sp;
	} tsodr_thread_t;

	typedef struct packed {
		logic global_debug_off;
		logic otp_read_lock;
		logic fuse_prog_lock;
		logic otp_combined;
		logic fuse_boot_override;
		logic jtag_cfg_lock;
		logic jtag_tap_off;
	} tsodr_locks_t;
endpackage

// file: testbench/tsodr_regs_tb.sv
// self-checking bench of the tile security, oscillator and debug registers
// assumes the register bank alone, all pins driven from here
`timescale 1ns/1ps
`default_nettype none
module tsodr_regs_tb;
	import tsodr_pkg::*;
	logic          clk = 1'b0;
	logic          rst = 1'b1;
	logic          por = 1'b1;
	tsodr_req_t    req = '0;
	logic [31:0]   rdata;
	logic          rvalid;
	logic [31:0]   otp = '0;
	logic          otp_v = 1'b0;
	logic          loaded;
	tsodr_locks_t  locks;
	logic [3:0]    osc = 4'h0;
	logic [3:0]    run;
	logic          dbg = 1'b0;
	logic          entry = 1'b0;
	tsodr_thread_t ts = '0;
	logic [7:0]    tid;
	int            fails = 0;
	int            n_tests = 0;
	int            cyc = 0;
	logic [31:0]   lf = 32'h00000020;
	logic [31:0]   sec;
	logic [31:0]   saved_status_word;
	logic [31:0]   cnt [4];

	tsodr_regs dut (.CLK(clk), .RST(rst), .POR_RST(por), .PS_REQ(req),
		.PS_RDATA(rdata), .PS_RVALID(rvalid), .OTP_SEC_WORD(otp),
		.OTP_SEC_VALID(otp_v), .SEC_LOADED(loaded), .SEC_LOCKS(locks),
		.OSC_IN(osc), .OSC_RUN(run), .DEBUG_MODE(dbg), .DBG_ENTRY(entry),
		.THREAD_STATE(ts), .TARGET_THREAD_ID(tid));

	initial forever #10 clk = ~clk;

	// hang guard, far above the roughly 160 cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			finish_test();
		end
	end

	function automatic logic [31:0] next_lf(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [31:0] lk(input logic [31:0] s);
		return {25'h0, s[14], s[9], s[8], s[7], s[5], s[4], s[0]};
	endfunction

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// idle cycle after each access so req never changes twice at once
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		step(1);
		req = '0;
		step(1);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		step(1);
		chk({31'h0, rvalid}, 32'h1);
		chk(rdata, exp);
		req = '0;
		step(1);
		chk({31'h0, rvalid}, 32'h0);
	endtask

	task automatic finish_test();
		$display("counts: %0d compares, %0d mismatches", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		step(10);
		rst = 1'b0;
		por = 1'b0;
		rd(OFS_RAM_SIZE, 32'h00080000 & RAM_ADDR_MASK);
		rd(OFS_OSC_CTRL, 32'h0);
		rd(8'h0B, 32'h0);
		$display("test reset done");
		lf = next_lf(lf);
		otp = lf & 32'h7FFFFFFF;
		otp_v = 1'b1;
		step(1);
		// a second valid with another word must be ignored
		otp = 32'hFFFFFFFF;
		step(1);
		otp_v = 1'b0;
		sec = lf & 32'h7FFFFFFF & SEC_MASK;
		chk({31'h0, loaded}, 32'h1);
		chk({25'h0, locks}, lk(sec));
		rd(OFS_SECURITY, sec);
		lf = next_lf(lf);
		wr(OFS_SECURITY, lf & 32'h7FFFFFFF);
		sec = lf & 32'h7FFFFFFF & SEC_MASK;
		rd(OFS_SECURITY, sec);
		chk({25'h0, locks}, lk(sec));
		wr(OFS_SECURITY, 32'hFFFFFFFF);
		wr(OFS_SECURITY, 32'h0);
		sec = SEC_MASK;
		rd(OFS_SECURITY, sec);
		chk({25'h0, locks}, lk(sec));
		$display("test security done");
		for (int v = 0; v < 4; v++) begin
			wr(OFS_OSC_CTRL, 32'hFFFFFFFC | 32'(v));
			rd(OFS_OSC_CTRL, 32'(v));
			chk({28'h0, run}, {28'h0, {2{v[0]}}, {2{v[1]}}});
		end
		wr(OFS_OSC_CTRL, 32'h0);
		for (int i = 0; i < 4; i++) begin
			cnt[i] = 32'(i) + 32'h1 + {29'h0, lf[i*3 +: 3]};
			repeat (cnt[i]) begin
				osc[i] = 1'b1;
				step(2);
				osc[i] = 1'b0;
				step(2);
			end
		end
		step(10);
		for (int i = 0; i < 4; i++)
			rd(OFS_OSC_CNT0 + 8'(i), cnt[i]);
		rst = 1'b1;
		step(2);
		rst = 1'b0;
		chk({31'h0, loaded}, 32'h0);
		for (int i = 0; i < 4; i++)
			rd(OFS_OSC_CNT0 + 8'(i), cnt[i]);
		rd(OFS_SECURITY, 32'h0);
		$display("test oscillator done");
		lf = next_lf(lf);
		ts = '{status: lf[10:0], pc: lf, sp: ~lf};
		entry = 1'b1;
		step(1);
		entry = 1'b0;
		ts = '0;
		saved_status_word = {21'h0, lf[10:0] & SSR_MASK};
		rd(OFS_DEBUG_STATUS_SNAPSHOT, saved_status_word);
		rd(OFS_DEBUG_PC_SNAPSHOT, lf);
		rd(OFS_DEBUG_STACK_SNAPSHOT, ~lf);
		for (int a = 16; a < 20; a++)
			wr(8'(a), 32'h0);
		rd(OFS_DEBUG_STATUS_SNAPSHOT, saved_status_word);
		rd(OFS_DEBUG_PC_SNAPSHOT, lf);
		dbg = 1'b1;
		wr(OFS_DEBUG_STATUS_SNAPSHOT, 32'hFFFFFFFF);
		wr(OFS_DBG_TSEL, 32'h000001A5);
		wr(OFS_DEBUG_PC_SNAPSHOT, 32'h0);
		saved_status_word = saved_status_word | {21'h0, SSR_WMASK};
		rd(OFS_DEBUG_STATUS_SNAPSHOT, saved_status_word);
		rd(OFS_DBG_TSEL, 32'hA5);
		chk({24'h0, tid}, 32'hA5);
		rd(OFS_DEBUG_PC_SNAPSHOT, 32'h0);
		dbg = 1'b0;
		$display("test debug done");
		finish_test();
	end
endmodule // tsodr_regs_tb
`default_nettype wire
